// >>> verilog/led_code_pkg.sv
// Constants for the indicator LED blink coder.
// Assumes a 200 MHz system clock.
`default_nettype none
package led_code_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned STARTUP_MS    = 2000;
  localparam int unsigned PULSE_MS      = 300;
  localparam int unsigned FRAME_MS      = 6000;
  localparam int unsigned STARTUP_CYC   = STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_CYC     = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned FRAME_SLOTS   = FRAME_MS / PULSE_MS;
  localparam int unsigned COUNT_W       = 32;
  localparam int unsigned SLOT_W        = 5;
  localparam int unsigned CODE_W        = 4;
  localparam logic [3:0]  PRIO_NONE     = 4'h0;
  localparam logic [3:0]  PRIO_INFO     = 4'h1;
  localparam logic [3:0]  PRIO_SENSOR   = 4'h3;
  localparam logic [3:0]  PRIO_SETUP    = 4'h5;
  localparam logic [3:0]  PRIO_REPLACE  = 4'h7;
  localparam logic [3:0]  PRIO_TEMP     = 4'h9;
  localparam logic [3:0]  PRIO_FIRST    = 4'hB;
  localparam logic [3:0]  PRIO_SECOND   = 4'hD;
endpackage
`default_nettype wire

// >>> verilog/led_code_select.sv
// Priority selector: picks highest active condition and its flash code.
// Assumes condition inputs are synchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module led_code_select (
  // Conditions
  input  wire logic       second_level_alarm_in,
  input  wire logic       first_level_alarm_in,
  input  wire logic       high_temp_in,
  input  wire logic       replace_err_in,
  input  wire logic       setup_err_in,
  input  wire logic       sensor_err_in,
  input  wire logic       info_event_in,
  // Result
  output logic [3:0]      prio_out,
  output logic [3:0]      code_out
);
  always_comb begin
    prio_out = led_code_pkg::PRIO_NONE;
    code_out = 4'h0;
    if (second_level_alarm_in) begin
      prio_out = led_code_pkg::PRIO_SECOND;
    end else if (first_level_alarm_in) begin
      prio_out = led_code_pkg::PRIO_FIRST;
    end else if (high_temp_in) begin
      prio_out = led_code_pkg::PRIO_TEMP;
    end else if (replace_err_in) begin
      prio_out = led_code_pkg::PRIO_REPLACE;
      code_out = led_code_pkg::PRIO_REPLACE;
    end else if (setup_err_in) begin
      prio_out = led_code_pkg::PRIO_SETUP;
      code_out = led_code_pkg::PRIO_SETUP;
    end else if (sensor_err_in) begin
      prio_out = led_code_pkg::PRIO_SENSOR;
      code_out = led_code_pkg::PRIO_SENSOR;
    end else if (info_event_in) begin
      prio_out = led_code_pkg::PRIO_INFO;
      code_out = led_code_pkg::PRIO_INFO;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/status_led_blink_coder.sv
// Indicator LED sequencer: startup lamp then repeating flash codes.
// Assumes condition inputs are level flags on CLOCK_IN; LED is active high.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - LED on two seconds after reset, then off or blinking per config.
// - Each pulse 0.3 s lit then 0.3 s dark; frame repeats every 6 s.
// - Pulses per frame equal the code; dark for rest of frame.
// - Radio or internal error is priority 7, flash code 7.
// - Settings recovery copy or setup error is priority 5, code 5.
// - Active or latched sensor error priority 3 code 3; cleared is 0.
// - Settings copies, log init, watchdog, auto-learn: priority 1, code 1.
// - Second-level low pressure alarm priority 13, LED off.
// - First-level alarms priority 11, high temperature 9, LED off.
module status_led_blink_coder #(
  parameter int unsigned STARTUP_CYC = led_code_pkg::STARTUP_CYC,
  parameter int unsigned PULSE_CYC   = led_code_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK_IN,
  input  wire logic       NRST_IN,
  // Configuration
  input  wire logic       BLINK_EN_IN,
  // Tire alarms, active or latched
  input  wire logic       SECOND_LEVEL_ALARM_IN,
  input  wire logic       FIRST_LEVEL_ALARM_IN,
  input  wire logic       HIGH_TEMP_IN,
  // Diagnostic conditions
  input  wire logic       RF_ERR_IN,
  input  wire logic       INTERNAL_ERR_IN,
  input  wire logic       RECOVERY_COPY_IN,
  input  wire logic       SETUP_ERR_IN,
  input  wire logic       SENSOR_ERR_IN,
  input  wire logic       INFO_EVENT_IN,
  // Outputs
  output logic            LED_OUT,
  output logic [3:0]      PRIO_OUT,
  output logic [3:0]      CODE_OUT,
  output logic            STARTUP_OUT
);
  typedef enum logic [0:0] {
    ST_STARTUP = 1'b0,
    ST_RUN     = 1'b1
  } state_e;

  state_e      state_q;
  logic [31:0] cnt_q;
  logic [4:0]  slot_q;
  logic [3:0]  code_q;
  logic        led_q;
  logic [3:0]  sel_prio;
  logic [3:0]  sel_code;
  logic        slot_end;
  logic        frame_end;
  logic        lit_d;
  // Checker helpers: sources that outrank the lower codes
  logic        alarm_any;
  logic        err_hi;

  assign alarm_any = SECOND_LEVEL_ALARM_IN | FIRST_LEVEL_ALARM_IN |
                     HIGH_TEMP_IN;
  assign err_hi    = RF_ERR_IN | INTERNAL_ERR_IN | RECOVERY_COPY_IN |
                     SETUP_ERR_IN;

  led_code_select u_sel (
    .second_level_alarm_in (SECOND_LEVEL_ALARM_IN),
    .first_level_alarm_in  (FIRST_LEVEL_ALARM_IN),
    .high_temp_in          (HIGH_TEMP_IN),
    .replace_err_in        (RF_ERR_IN | INTERNAL_ERR_IN),
    .setup_err_in          (RECOVERY_COPY_IN | SETUP_ERR_IN),
    .sensor_err_in         (SENSOR_ERR_IN),
    .info_event_in         (INFO_EVENT_IN),
    .prio_out              (sel_prio),
    .code_out              (sel_code)
  );

  assign slot_end  = (cnt_q == 32'(PULSE_CYC - 1));
  assign frame_end = slot_end &&
                     (slot_q == 5'(led_code_pkg::FRAME_SLOTS - 1));

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= ST_STARTUP;
    end else if (state_q == ST_STARTUP &&
                 cnt_q == 32'(STARTUP_CYC - 1)) begin
      state_q <= ST_RUN;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt_q  <= 32'h0;
      slot_q <= 5'h0;
    end else begin
      case (state_q)
        ST_STARTUP: begin
          if (cnt_q == 32'(STARTUP_CYC - 1)) begin
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_RUN: begin
          if (slot_end) begin
            cnt_q  <= 32'h0;
            slot_q <= frame_end ? 5'h0 : slot_q + 5'h1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: begin
          cnt_q  <= 32'h0;
          slot_q <= 5'h0;
        end
      endcase
    end
  end

  // Code latched only at frame boundaries so a frame is never cut short
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      code_q <= 4'h0;
    end else if (state_q == ST_STARTUP &&
                 cnt_q == 32'(STARTUP_CYC - 1)) begin
      code_q <= BLINK_EN_IN ? sel_code : 4'h0;
    end else if (state_q == ST_RUN && frame_end) begin
      code_q <= BLINK_EN_IN ? sel_code : 4'h0;
    end
  end

  // Even slots lit while slot/2 is below the code, odd dark; lit pulse index is slot/2
  always_comb begin
    lit_d = 1'b0;
    if (state_q == ST_STARTUP) begin
      lit_d = 1'b1;
    end else if (!slot_q[0] && (slot_q[4:1] < code_q)) begin
      lit_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      led_q <= 1'b1;
    end else begin
      led_q <= lit_d;
    end
  end

  assign LED_OUT     = led_q;
  assign PRIO_OUT    = sel_prio;
  assign CODE_OUT    = code_q;
  assign STARTUP_OUT = (state_q == ST_STARTUP);

  a_startup_lit: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_STARTUP) |=> LED_OUT
  ) else $error("LED dark during startup");

  a_startup_len: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_STARTUP) |-> cnt_q < 32'(STARTUP_CYC)
  ) else $error("Startup count overran");

  a_startup_exit: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_STARTUP && cnt_q == 32'(STARTUP_CYC - 1)) |=>
      (state_q == ST_RUN && cnt_q == 32'h0 && slot_q == 5'h0)
  ) else $error("Startup did not end on time");

  a_blink_off: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (((state_q == ST_STARTUP && cnt_q == 32'(STARTUP_CYC - 1)) ||
      (state_q == ST_RUN && frame_end)) && !BLINK_EN_IN) |=>
      code_q == 4'h0
  ) else $error("Code taken while blinking disabled");

  a_slot_len: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RUN && slot_end) |=> cnt_q == 32'h0
  ) else $error("Slot timer not restarted");

  a_frame_wrap: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RUN && frame_end) |=> slot_q == 5'h0
  ) else $error("Frame did not wrap at 20 slots");

  a_dark_tail: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RUN && slot_q[4:1] >= code_q) |=> !LED_OUT
  ) else $error("LED lit past code pulses");

  a_pulse_lit: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RUN && !slot_q[0] && slot_q[4:1] < code_q) |=> LED_OUT
  ) else $error("Code pulse missing");

  a_odd_dark: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RUN && slot_q[0]) |=> !LED_OUT
  ) else $error("LED lit in gap slot");

  a_replace_code: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (RF_ERR_IN && !SECOND_LEVEL_ALARM_IN && !FIRST_LEVEL_ALARM_IN &&
     !HIGH_TEMP_IN) |-> sel_code == 4'h7 && PRIO_OUT == 4'h7
  ) else $error("Radio error not code 7");

  a_internal_code: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (INTERNAL_ERR_IN && !alarm_any) |-> sel_code == 4'h7 && PRIO_OUT == 4'h7
  ) else $error("Internal error not code 7");

  a_setup_code: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    ((RECOVERY_COPY_IN || SETUP_ERR_IN) && !alarm_any && !RF_ERR_IN &&
     !INTERNAL_ERR_IN) |-> sel_code == 4'h5 && PRIO_OUT == 4'h5
  ) else $error("Settings error not code 5");

  a_sensor_code: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (SENSOR_ERR_IN && !alarm_any && !err_hi) |->
      sel_code == 4'h3 && PRIO_OUT == 4'h3
  ) else $error("Sensor error not code 3");

  a_info_code: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (INFO_EVENT_IN && !alarm_any && !err_hi && !SENSOR_ERR_IN) |->
      sel_code == 4'h1 && PRIO_OUT == 4'h1
  ) else $error("Info event not code 1");

  a_alarm_dark: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    SECOND_LEVEL_ALARM_IN |-> sel_code == 4'h0 && PRIO_OUT == 4'hD
  ) else $error("Tire alarm lit LED");

  a_idle_none: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (!alarm_any && !err_hi && !SENSOR_ERR_IN && !INFO_EVENT_IN) |->
      sel_code == 4'h0 && PRIO_OUT == 4'h0
  ) else $error("Idle priority not zero");

  a_first_dark: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (!SECOND_LEVEL_ALARM_IN && FIRST_LEVEL_ALARM_IN) |->
      sel_code == 4'h0 && PRIO_OUT == 4'hB
  ) else $error("First level alarm lit LED");

  a_temp_dark: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (!SECOND_LEVEL_ALARM_IN && !FIRST_LEVEL_ALARM_IN && HIGH_TEMP_IN) |->
      sel_code == 4'h0 && PRIO_OUT == 4'h9
  ) else $error("Temperature alarm lit LED");

  a_code_hold: assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RUN && !frame_end) |=> $stable(code_q)
  ) else $error("Code changed mid frame");
endmodule
`default_nettype wire

// >>> bench/led_model.sv
// Front LED model: measures lit pulses and reports the count per frame.
// Assumes an active-high LED sampled on the system clock.
`timescale 1ns/100ps
`default_nettype none
module led_model #(
  parameter int unsigned PULSE = 4
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       led_in,
  output logic            rep_out,
  output logic [3:0]      cnt_out,
  output logic            shape_ok_out
);
  int unsigned run_q;
  logic        led_q;
  logic [3:0]  cnt_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q <= 0;
      led_q <= 1'b1;
      cnt_q <= 4'h0;
      rep_out <= 1'b0;
      cnt_out <= 4'h0;
      shape_ok_out <= 1'b1;
    end else begin
      led_q <= led_in;
      rep_out <= 1'b0;
      if (led_in != led_q) begin
        run_q <= 1;
        // Long lit run is the startup lamp, not a flash
        if (led_q && run_q == PULSE) cnt_q <= cnt_q + 4'h1;
        else if (led_q && run_q <= 2 * PULSE) shape_ok_out <= 1'b0;
        if (!led_q && cnt_q != 0 && run_q != PULSE) begin
          shape_ok_out <= 1'b0;
        end
      end else begin
        run_q <= run_q + 1;
      end
      if (!led_in && !led_q && run_q == PULSE + 1 && cnt_q != 0) begin
        rep_out <= 1'b1;
        cnt_out <= cnt_q;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/status_led_blink_coder_tb.sv
// Bench for the LED blink coder: conditions in, pulse counts checked.
// Assumes short startup and pulse counts; the LED is watched by led_model.
`timescale 1ns/100ps
`default_nettype none
module status_led_blink_coder_tb;
  localparam int unsigned SU = 40;
  localparam int unsigned PC = 4;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       blink = 1'b0;
  logic [8:0] cond = 9'h000;
  logic       led, st, rep, ok;
  logic [3:0] prio, code, cnt;
  logic [3:0] notes[$];
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc = 0;
  always #2.5 clk = ~clk;
  status_led_blink_coder #(.STARTUP_CYC(SU), .PULSE_CYC(PC))
    u_status_led_blink_coder (
    .CLOCK_IN(clk), .NRST_IN(nrst), .BLINK_EN_IN(blink),
    .SECOND_LEVEL_ALARM_IN(cond[8]), .FIRST_LEVEL_ALARM_IN(cond[7]),
    .HIGH_TEMP_IN(cond[6]), .RF_ERR_IN(cond[5]), .INTERNAL_ERR_IN(cond[4]),
    .RECOVERY_COPY_IN(cond[3]), .SETUP_ERR_IN(cond[2]),
    .SENSOR_ERR_IN(cond[1]), .INFO_EVENT_IN(cond[0]), .LED_OUT(led),
    .PRIO_OUT(prio), .CODE_OUT(code), .STARTUP_OUT(st));
  led_model #(.PULSE(PC)) u_led_model (.clk_in(clk), .nrst_in(nrst),
    .led_in(led), .rep_out(rep), .cnt_out(cnt), .shape_ok_out(ok));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Hang guard, well above the planned run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  always @(posedge clk) begin
    if (rep === 1'b1 && notes.size() != 0) begin
      check({4'h0, cnt}, {4'h0, notes.pop_front()});
      check({7'h00, ok}, 8'h01);
    end
  end
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (SU / 2) @(posedge clk);
    #1 check({6'h00, led, st}, 8'h03);
    repeat (SU) @(posedge clk);
    #1 check({7'h00, st}, 8'h00);
  endtask
  task automatic run_case(input logic [8:0] c, input logic b);
    logic [7:0] p;
    logic [7:0] e;
    int         lit;
    p = c[8] ? 8'h0D : c[7] ? 8'h0B : c[6] ? 8'h09 : |c[5:4] ? 8'h07
      : |c[3:2] ? 8'h05 : c[1] ? 8'h03 : c[0] ? 8'h01 : 8'h00;
    e = (b && p < 8'h09) ? p : 8'h00;
    @(posedge clk);
    cond <= c;
    blink <= b;
    @(posedge clk);
    #1 check({4'h0, prio}, p);
    repeat (80) @(posedge clk);
    #1 check({4'h0, code}, e);
    if (e != 0) notes.push_back(e[3:0]);
    lit = 0;
    repeat (80) begin
      @(posedge clk);
      #1 lit += (led === 1'b1);
    end
    check(8'(lit), 8'(e * PC));
    repeat (80) @(posedge clk);
    check(8'(notes.size()), 8'h00);
  endtask
  initial begin
    void'($urandom(78071));
    do_reset();
    for (int i = 0; i < 9; i++) run_case(9'h001 << i, 1'b1);
    run_case(9'h020, 1'b0);
    for (int i = 0; i < 24; i++)
      run_case(9'($urandom) & (i % 4 == 0 ? 9'h1FF : 9'h03F), 1'b1);
    do_reset();
    run_case(9'h00A, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
